// ---- verification/bdm_core_monitor.sv ----
/*
  Checker for the bdm_core ports: quarter sequencing, address forming,
  pulses and handshakes. Assumes it is bound onto every bdm_core.
*/
`timescale 1ns/1ns
`default_nettype none

module bdm_core_monitor (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // decoder side
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_word_i,
  input wire logic op_ldbank_i,
  input wire logic op_wr_i,
  input wire logic extended_isa_enable_i,
  input wire logic [11:0] fsr2_i,
  input wire logic [1:0] q_phase_o,
  input wire logic [7:0] data_rd_o,
  input wire logic nop_o,
  input wire logic [3:0] bank_select_reg_o,
  // special register and usb side
  input wire logic [11:0] sfr_addr_o,
  input wire logic sfr_wr_o,
  input wire logic pcl_wr_o,
  input wire logic usb_en_i,
  input wire logic usb_req_i,
  input wire logic usb_ack_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // ===========================================================
  // helpers
  logic [3:0] op;
  logic take;
  logic plain;
  logic orphan;
  logic [11:0] win_addr;
  logic [11:0] bank_addr;
  logic [11:0] ext_addr;
  assign op = instr_word_i[15:12];
  assign take = q_phase_o == 2'h0 && instr_valid_i;
  assign plain = take && op != 4'hc && op != 4'hf && !op_ldbank_i;
  assign orphan = take && op == 4'hf;
  assign win_addr = {instr_word_i[7:0] >= 8'h60 ? 4'hf : 4'h0,
                     instr_word_i[7:0]};
  assign bank_addr = {bank_select_reg_o, instr_word_i[7:0]};
  assign ext_addr = fsr2_i + {4'h0, instr_word_i[7:0]};

  sequence ld_take_s;
    take && op_ldbank_i && !op_wr_i;
  endsequence
  sequence win_take_s;
    plain && !instr_word_i[8];
  endsequence

  // ===========================================================
  // properties
  phase_step_a: assert property ($past(rstn_i) |->
    q_phase_o == $past(q_phase_o) + 2'h1) else $error("phase skipped");
  full_move_a: assert property (take && op == 4'hc |=>
    sfr_addr_o == $past(instr_word_i[11:0])) else $error("move address");
  bank_addr_a: assert property (plain && instr_word_i[8] |=>
    sfr_addr_o == $past(bank_addr)) else $error("bank address");
  window_addr_a: assert property (win_take_s ##0
    (instr_word_i[7:0] >= 8'h60 || !extended_isa_enable_i) |=>
    sfr_addr_o == $past(win_addr)) else $error("window address");
  ext_window_a: assert property (win_take_s ##0
    (instr_word_i[7:0] < 8'h60 && extended_isa_enable_i) |=>
    sfr_addr_o == $past(ext_addr)) else $error("extended window");
  load_bank_a: assert property (ld_take_s |-> ##4
    bank_select_reg_o == $past(instr_word_i[3:0], 4)) else $error("ldbank");
  bank_moment_a: assert property ($changed(bank_select_reg_o) |->
    q_phase_o == 2'h0) else $error("bank moved mid cycle");
  read_moment_a: assert property ($changed(data_rd_o) |->
    q_phase_o == 2'h2) else $error("read data moved");
  nop_pulse_a: assert property (nop_o |-> q_phase_o == 2'h1 &&
    $past(orphan) ##1 !nop_o) else $error("nop pulse");
  pcl_write_a: assert property (pcl_wr_o |->
    sfr_wr_o && sfr_addr_o == 12'hff9) else $error("pcl write");
  sfr_write_a: assert property (sfr_wr_o |-> q_phase_o == 2'h0 &&
    sfr_addr_o >= 12'hf40 && sfr_addr_o != 12'hfe0 ##1 !sfr_wr_o)
    else $error("sfr write");
  usb_ack_a: assert property (usb_en_i && usb_req_i &&
    !q_phase_o[0] |=> usb_ack_o ##1 !usb_ack_o) else $error("usb ack");
endmodule

bind bdm_core bdm_core_monitor bdm_core_monitor_inst (.*);

`default_nettype wire

// ---- verification/bdm_sfr_model.sv ----
/*
  Special register bank beside the core: answers F40h and above.
  Assumes the core samples hit and data in the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module bdm_sfr_model (
  // special register port of the core
  input wire logic [11:0] sfr_addr_i,
  output logic sfr_hit_o,
  output logic [7:0] sfr_rdata_o
);
  // ===========================================================
  // data is the low address byte so reads are traceable; an idle
  // port shows the inverse, never a stale value
  assign sfr_hit_o = sfr_addr_i >= 12'hf40;
  assign sfr_rdata_o = sfr_hit_o ? sfr_addr_i[7:0] : ~sfr_addr_i[7:0];
endmodule

`default_nettype wire

// ---- verification/test_banked_data_memory_addressing.sv ----
/*
  Bench for bdm_core: one task per scenario, register model beside it.
  Assumes design, model and checker are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none

module test_banked_data_memory_addressing;
  localparam logic [2:0] RD = 3'b100;
  localparam logic [2:0] WR = 3'b010;
  localparam logic [2:0] LD = 3'b001;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [15:0] instr_word_i = 16'h0;
  logic op_rd_i = 1'b0;
  logic op_wr_i = 1'b0;
  logic op_ldbank_i = 1'b0;
  logic [7:0] wr_data_i = 8'h0;
  logic extended_isa_enable_i = 1'b0;
  logic [11:0] fsr2_i = 12'h0;
  logic usb_en_i = 1'b1;
  logic usb_req_i = 1'b0;
  logic usb_we_i = 1'b0;
  logic [11:0] usb_addr_i = 12'h0;
  logic [7:0] usb_wdata_i = 8'h0;
  logic sfr_hit_i;
  logic [7:0] sfr_rdata_i;
  logic [1:0] q_phase_o;
  logic [7:0] data_rd_o;
  logic nop_o;
  logic access_void_o;
  logic [3:0] bank_select_reg_o;
  logic [11:0] sfr_addr_o;
  logic sfr_wr_o;
  logic [7:0] sfr_wdata_o;
  logic pcl_wr_o;
  logic [7:0] usb_rdata_o;
  logic usb_ack_o;
  logic [7:0] q;
  logic nv;
  logic ok;
  int failures = 0;
  int n_checks = 0;

  // shrunken store: banks 0-2 exist, bank 3 up to F3Fh reads zero
  bdm_core #(.GPR_DEPTH(768)) bdm_core_inst (.*);
  bdm_sfr_model bdm_sfr_model_inst (
    .sfr_addr_i(sfr_addr_o),
    .sfr_hit_o(sfr_hit_i),
    .sfr_rdata_o(sfr_rdata_i)
  );

  always #5 ref_clk_i = ~ref_clk_i;

  // ===========================================================
  // shared tasks
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic do_reset();
    rstn_i = 1'b0;
    repeat (10) @(negedge ref_clk_i);
    rstn_i = 1'b1;
  endtask

  // one whole instruction cycle; returns at the next cycle's Q1
  task automatic ins(input logic [15:0] w, input logic [2:0] k,
                     input logic [7:0] d);
    int n;
    n = 0;
    while (q_phase_o !== 2'h0 && n < 8) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 8) begin
      failures++;
      end_of_test();
    end
    instr_valid_i = 1'b1;
    instr_word_i = w;
    {op_rd_i, op_wr_i, op_ldbank_i} = k;
    wr_data_i = d;
    @(negedge ref_clk_i);
    instr_valid_i = 1'b0;
    nv = nop_o;
    @(negedge ref_clk_i);
    q = data_rd_o;
    repeat (2) @(negedge ref_clk_i);
  endtask

  task automatic usb(input logic we, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    ok = 1'b0;
    usb_req_i = 1'b1;
    usb_we_i = we;
    usb_addr_i = a;
    usb_wdata_i = d;
    while (ok !== 1'b1 && n < 8) begin
      @(negedge ref_clk_i);
      ok = usb_ack_o;
      n++;
    end
    if (usb_en_i && ok !== 1'b1) begin
      failures++;
      end_of_test();
    end
    q = usb_rdata_o;
    usb_req_i = 1'b0;
    @(negedge ref_clk_i);
  endtask

  // ===========================================================
  // scenarios
  task automatic t_bank();
    chk("bank reset", 8'h00, 8'(bank_select_reg_o));
    ins(16'h00f2, LD, 8'h00);
    chk("bank load", 8'h02, 8'(bank_select_reg_o));
    ins(16'h00e0, WR, 8'hf1);
    chk("bank write", 8'h01, 8'(bank_select_reg_o));
    ins(16'h00e0, RD, 8'h00);
    chk("bank read", 8'h01, q);
    $display("test bank done");
  endtask

  task automatic t_rw();
    ins(16'h0110, WR, 8'ha5);
    ins(16'h0000, WR, 8'h3c);
    ins(16'h0000, RD, 8'h00);
    chk("window 000h", 8'h3c, q);
    ins(16'h0110, RD, 8'h00);
    chk("bank 110h", 8'ha5, q);
    extended_isa_enable_i = 1'b1;
    fsr2_i = 12'h110;
    ins(16'h0000, RD, 8'h00);
    chk("ext window", 8'ha5, q);
    extended_isa_enable_i = 1'b0;
    $display("test rw done");
  endtask

  task automatic t_void();
    ins(16'h0002, LD, 8'h00);
    ins(16'h01ff, WR, 8'h5e);
    ins(16'h01ff, RD, 8'h00);
    chk("top byte", 8'h5e, q);
    chk("void clear", 8'h00, 8'(access_void_o));
    ins(16'h0003, LD, 8'h00);
    ins(16'h0100, WR, 8'h77);
    chk("void write", 8'h01, 8'(access_void_o));
    ins(16'h0100, RD, 8'h00);
    chk("void read", 8'h00, q);
    $display("test void done");
  endtask

  task automatic t_pcl();
    ins(16'h000f, LD, 8'h00);
    for (int i = 0; i < 2; i++) begin
      ins(i == 0 ? 16'h01f9 : 16'h00f9, WR, 8'h42);
      chk("pcl strobe", 8'h01, 8'(pcl_wr_o & sfr_wr_o));
      chk("pcl data", 8'h42, sfr_wdata_o);
    end
    ins(16'h0061, WR, 8'h24);
    chk("sfr no pcl", 8'h02, 8'({sfr_wr_o, pcl_wr_o}));
    ins(16'h0061, RD, 8'h00);
    chk("window sfr", 8'h61, q);
    ins(16'h0130, RD, 8'h00);
    chk("gap f30h", 8'h00, q);
    $display("test pcl done");
  endtask

  task automatic t_move();
    do_reset();
    ins(16'h0000, RD, 8'h00);
    chk("kept by reset", 8'h3c, q);
    ins(16'hc000, RD, 8'h00);
    ins(16'hf020, WR, 8'h00);
    ins(16'h0020, RD, 8'h00);
    chk("move target", 8'h3c, q);
    ins(16'h0021, WR, 8'h11);
    ins(16'hf021, WR, 8'h00);
    chk("orphan nop", 8'h01, 8'(nv));
    ins(16'h0021, RD, 8'h00);
    chk("orphan no write", 8'h11, q);
    $display("test move done");
  endtask

  task automatic t_usb();
    usb(1'b1, 12'h150, 8'h99);
    chk("usb write ack", 8'h01, 8'(ok));
    ins(16'h0001, LD, 8'h00);
    ins(16'h0150, RD, 8'h00);
    chk("core sees usb", 8'h99, q);
    usb(1'b0, 12'h110, 8'h00);
    chk("usb read", 8'ha5, q);
    usb_en_i = 1'b0;
    usb(1'b0, 12'h110, 8'h00);
    chk("usb off", 8'h00, 8'(ok));
    $display("test usb done");
  endtask

  initial begin
    do_reset();
    t_bank();
    t_rw();
    t_void();
    t_pcl();
    t_move();
    t_usb();
    end_of_test();
  end
endmodule

`default_nettype wire

// ---- verilog/bdm_addr_gen.sv ----
/*
  Data address selector: full address, access window or bank plus offset.
  Assumes every input comes from logic on the same clock; purely combinational.
*/
`timescale 1ns/1ns
`default_nettype none

module bdm_addr_gen
  import bdm_pkg::*;
(
  // instruction fields
  input wire logic full_move_i,
  input wire logic [11:0] full_addr_i,
  input wire logic win_sel_i,
  input wire logic [7:0] offset_i,
  // context
  input wire logic [3:0] bank_i,
  input wire logic ext_isa_i,
  input wire logic [11:0] fsr2_i,
  // result
  output logic [11:0] addr_o
);

  always_comb begin
    if (full_move_i) begin
      addr_o = full_addr_i;
    end else if (!win_sel_i) begin
      // window map ignores the bank register entirely
      if (ext_isa_i && offset_i < WIN_SPLIT) begin
        addr_o = fsr2_i + {4'h0, offset_i};
      end else if (offset_i < WIN_SPLIT) begin
        addr_o = {WIN_LOW_BANK, offset_i};
      end else begin
        addr_o = {WIN_HIGH_BANK, offset_i};
      end
    end else begin
      addr_o = {bank_i, offset_i};
    end
  end

endmodule

`default_nettype wire

// ---- verilog/bdm_core.sv ----
/*
  Banked data memory addressing: bank select, address forming, quarter
  sequencing, shared storage with the USB engine, special register port.
  Assumes the decoder and USB engine run on ref_clk_i, and the decoder holds
  the instruction word steady during quarter one of each instruction cycle.
  Storage past GPR_DEPTH and below the special registers reads zero.
*/
`timescale 1ns/1ns
`default_nettype none

module bdm_core
  import bdm_pkg::*;
#(
  parameter int GPR_DEPTH = GPR_BYTES
)
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // instruction decoder
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_word_i,
  input wire logic op_rd_i,
  input wire logic op_wr_i,
  input wire logic op_ldbank_i,
  input wire logic [7:0] wr_data_i,
  input wire logic extended_isa_enable_i,
  input wire logic [11:0] fsr2_i,
  output logic [1:0] q_phase_o,
  output logic [7:0] data_rd_o,
  output logic nop_o,
  output logic access_void_o,
  output logic [3:0] bank_select_reg_o,
  // special register port
  input wire logic sfr_hit_i,
  input wire logic [7:0] sfr_rdata_i,
  output logic [11:0] sfr_addr_o,
  output logic sfr_wr_o,
  output logic [7:0] sfr_wdata_o,
  output logic pcl_wr_o,
  // usb serial engine
  input wire logic usb_en_i,
  input wire logic usb_req_i,
  input wire logic usb_we_i,
  input wire logic [11:0] usb_addr_i,
  input wire logic [7:0] usb_wdata_i,
  output logic [7:0] usb_rdata_o,
  output logic usb_ack_o
);

  // ===========================================================
  // state
  typedef struct packed {
    bdm_phase_t phase;
    logic [3:0] bank;
    logic move_pend;
    logic [11:0] addr;
    logic rd;
    logic wr;
    logic ldbank;
    logic [3:0] lit;
    logic move_wr;
    logic [7:0] rd_data;
    logic nop;
    logic void_acc;
    logic [7:0] usb_rdata;
    logic usb_ack;
    logic [11:0] sfr_addr;
    logic sfr_wr;
    logic [7:0] sfr_wdata;
    logic pcl_wr;
  } bdm_state_t;

  bdm_state_t q;
  bdm_state_t next_q;

  bdm_ram_if ram ();

  logic [3:0] opcode;
  logic is_first_move;
  logic is_second_word;
  logic [11:0] gen_addr;
  logic core_slot;
  logic usb_slot;
  logic usb_in_gpr;
  logic [7:0] wdata_sel;
  logic at_gpr;
  logic at_bank_sel;
  logic at_sfr;

  // ===========================================================
  // address forming
  assign opcode = instr_word_i[15:12];
  assign is_first_move = (opcode == MOVE_FIRST_OP);
  assign is_second_word = (opcode == SECOND_WORD_OP);

  bdm_addr_gen u_addr_gen (
    .full_move_i (is_first_move || is_second_word),
    .full_addr_i (instr_word_i[11:0]),
    .win_sel_i (instr_word_i[WIN_BIT]),
    .offset_i (instr_word_i[7:0]),
    .bank_i (q.bank),
    .ext_isa_i (extended_isa_enable_i),
    .fsr2_i (fsr2_i),
    .addr_o (gen_addr)
  );

  // ===========================================================
  // storage
  bdm_ram #(
    .DEPTH (GPR_DEPTH)
  ) u_ram (
    .ref_clk_i (ref_clk_i),
    .ram (ram)
  );

  // ===========================================================
  // helpers
  // the window and the bank path both land here; shrinking GPR_DEPTH
  // for simulation opens a gap that reads zero
  function automatic logic in_gpr(input logic [11:0] a);
    in_gpr = (32'(a) < GPR_DEPTH) && (a < SFR_BASE);
  endfunction

  function automatic logic in_sfr(input logic [11:0] a);
    in_sfr = (a >= SFR_BASE) && (a <= SFR_TOP);
  endfunction

  // core owns quarters two and four; the engine gets one and three
  assign core_slot = (q.phase == BDM_Q2) || (q.phase == BDM_Q4);
  assign usb_slot = !core_slot && usb_en_i && usb_req_i;
  assign usb_in_gpr = in_gpr(usb_addr_i);
  assign wdata_sel = q.move_wr ? q.rd_data : wr_data_i;

  // ===========================================================
  // region of the latched operand address
  // decoded once, so the quarter-two read and the quarter-four write
  // can never disagree about where one address lands
  always_comb begin
    at_gpr = 1'b0;
    at_bank_sel = 1'b0;
    at_sfr = 1'b0;
    if (in_gpr(q.addr)) begin
      at_gpr = 1'b1;
    end else if (q.addr == BANK_SEL_ADDR) begin
      at_bank_sel = 1'b1;
    end else if (in_sfr(q.addr)) begin
      at_sfr = 1'b1;
    end
  end

  // ===========================================================
  // storage port multiplexer
  always_comb begin
    ram.addr = q.addr;
    ram.we = 1'b0;
    ram.wdata = wdata_sel;
    if (q.phase == BDM_Q4) begin
      ram.we = q.wr && at_gpr;
    end else if (usb_slot) begin
      // bank 4 holds buffer bookkeeping; the core is trusted to keep off it
      ram.addr = usb_addr_i;
      ram.wdata = usb_wdata_i;
      ram.we = usb_we_i && usb_in_gpr;
    end
  end

  // ===========================================================
  // sequencing
  always_comb begin
    next_q = q;
    next_q.phase = bdm_phase_t'(q.phase + 2'b01);
    next_q.nop = 1'b0;
    next_q.usb_ack = 1'b0;
    next_q.sfr_wr = 1'b0;
    next_q.pcl_wr = 1'b0;

    // the engine never meets the core on the storage port: it only gets
    // the quarters in which the core leaves the array idle
    if (usb_slot) begin
      next_q.usb_ack = 1'b1;
      next_q.usb_rdata = usb_in_gpr ? ram.rdata : 8'h00;
    end

    case (q.phase)
      BDM_Q1: begin
        next_q.rd = 1'b0;
        next_q.wr = 1'b0;
        next_q.ldbank = 1'b0;
        next_q.move_wr = 1'b0;
        next_q.void_acc = 1'b0;
        // any word but the matching second word breaks a pending move pair
        next_q.move_pend = 1'b0;
        if (instr_valid_i) begin
          next_q.addr = gen_addr;
          next_q.sfr_addr = gen_addr;
          next_q.lit = instr_word_i[3:0];
          if (is_first_move) begin
            next_q.rd = 1'b1;
            next_q.move_pend = 1'b1;
          end else if (is_second_word) begin
            if (q.move_pend) begin
              next_q.wr = 1'b1;
              next_q.move_wr = 1'b1;
            end else begin
              next_q.nop = 1'b1;
            end
          end else begin
            next_q.rd = op_rd_i;
            next_q.wr = op_wr_i;
            next_q.ldbank = op_ldbank_i;
          end
        end
      end
      BDM_Q2: begin
        if (q.rd) begin
          if (at_gpr) begin
            next_q.rd_data = ram.rdata;
          end else if (at_bank_sel) begin
            next_q.rd_data = {4'h0, q.bank};
          end else if (at_sfr && sfr_hit_i) begin
            next_q.rd_data = sfr_rdata_i;
          end else begin
            next_q.rd_data = 8'h00;
            next_q.void_acc = 1'b1;
          end
        end
      end
      BDM_Q3: begin
        // the operand stands from quarter three until the next read; nothing moves
        next_q.rd_data = q.rd_data;
      end
      BDM_Q4: begin
        // a write to the bank select address below overrides the literal
        if (q.ldbank) begin
          next_q.bank = q.lit;
        end
        if (q.wr) begin
          if (at_gpr) begin
            next_q.void_acc = 1'b0;
          end else if (at_bank_sel) begin
            next_q.bank = wdata_sel[3:0];
          end else if (at_sfr) begin
            next_q.sfr_wr = 1'b1;
            next_q.sfr_wdata = wdata_sel;
            next_q.pcl_wr = (q.addr == PC_LOW_ADDR);
          end else begin
            // dropped from storage; the core flags it on access_void_o
            next_q.void_acc = 1'b1;
          end
        end
      end
      default: begin
        next_q.phase = BDM_Q1;
      end
    endcase
  end

  // ===========================================================
  // registers
  // storage is kept out of this state on purpose: it lives in u_ram,
  // which has no reset, so no reset source can touch its contents
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      q.phase <= BDM_Q1;
      q.bank <= BANK_SEL_RST;
      q.move_pend <= 1'b0;
      q.addr <= 12'h000;
      q.rd <= 1'b0;
      q.wr <= 1'b0;
      q.ldbank <= 1'b0;
      q.lit <= 4'h0;
      q.move_wr <= 1'b0;
      q.rd_data <= 8'h00;
      q.nop <= 1'b0;
      q.void_acc <= 1'b0;
      q.usb_rdata <= 8'h00;
      q.usb_ack <= 1'b0;
      q.sfr_addr <= 12'h000;
      q.sfr_wr <= 1'b0;
      q.sfr_wdata <= 8'h00;
      q.pcl_wr <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // ===========================================================
  // outputs, all straight from flops
  assign q_phase_o = q.phase;
  assign data_rd_o = q.rd_data;
  assign nop_o = q.nop;
  assign access_void_o = q.void_acc;
  assign bank_select_reg_o = q.bank;
  assign sfr_addr_o = q.sfr_addr;
  assign sfr_wr_o = q.sfr_wr;
  assign sfr_wdata_o = q.sfr_wdata;
  assign pcl_wr_o = q.pcl_wr;
  assign usb_rdata_o = q.usb_rdata;
  assign usb_ack_o = q.usb_ack;

endmodule

`default_nettype wire

// ---- verilog/bdm_pkg.sv ----
/*
  Constants and types shared by the banked data memory addressing block.
  This file assumes that it is compiled before every other design file.
*/
// Notes on behaviour
// - data addresses are 12 bits wide, reaching at most 4096 bytes
// - memory splits into up to 16 contiguous banks of 256 bytes
// - all banks exist; 3904 bytes serve as user storage
// - reads of unimplemented locations return all zeros
// - shared RAM is plain storage, or a shared buffer while USB engine runs
// - banked address is the 4-bit bank above the 8-bit offset
// - bank select keeps four low bits; upper bits read zero, ignore writes
// - the load-bank instruction writes its literal into bank select
// - writes to unimplemented space are dropped, reads give zero
// - full-address move uses 12-bit source and target, ignores bank select
// - offset F9h in bank 0Fh reaches the program counter low byte
// - window maps 00h-5Fh to bank 0 start, 60h-FFh to bank 15 top
// - window bit 1 uses bank plus offset; bit 0 uses the window map
// - window accesses finish in one instruction cycle, no bank update
// - extended instruction set bit set alters the window mapping
// - general storage starts at 000h and grows toward special registers
// - general storage is never initialised nor changed by any reset
// - an orphaned second word with top nibble 1111 runs as no-op
// - special registers occupy F40h through FFFh at top of bank 15
// - operands are read in quarter two, destinations written in four
`default_nettype none

package bdm_pkg;

  // ===========================================================
  // widths and sizes
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int OFS_W = 8;
  localparam int MEM_BYTES = 4096;
  localparam int BANK_COUNT = 16;
  localparam int BANK_BYTES = 256;
  localparam int GPR_BYTES = 3904;

  // ===========================================================
  // address map
  localparam logic [11:0] GPR_BASE = 12'h000;
  localparam logic [11:0] SFR_BASE = 12'hf40;
  localparam logic [11:0] SFR_TOP = 12'hfff;
  localparam logic [11:0] BANK_SEL_ADDR = 12'hfe0;
  localparam logic [11:0] PC_LOW_ADDR = 12'hff9;
  localparam logic [7:0] WIN_SPLIT = 8'h60;
  localparam logic [3:0] WIN_LOW_BANK = 4'h0;
  localparam logic [3:0] WIN_HIGH_BANK = 4'hf;

  // ===========================================================
  // reset values and opcode fields
  localparam logic [3:0] BANK_SEL_RST = 4'h0;
  localparam logic [3:0] MOVE_FIRST_OP = 4'hc;
  localparam logic [3:0] SECOND_WORD_OP = 4'hf;
  localparam int WIN_BIT = 8;

  // ===========================================================
  // instruction cycle quarters, one clock each
  typedef enum logic [1:0] {
    BDM_Q1 = 2'b00,
    BDM_Q2 = 2'b01,
    BDM_Q3 = 2'b10,
    BDM_Q4 = 2'b11
  } bdm_phase_t;

endpackage

`default_nettype wire

// ---- verilog/bdm_ram.sv ----
/*
  General storage array held in flip-flops, indexed by address.
  Assumes the controller never writes at or above DEPTH; such writes drop.
*/
`timescale 1ns/1ns
`default_nettype none

module bdm_ram
  import bdm_pkg::*;
#(
  parameter int DEPTH = GPR_BYTES
)
(
  // clock
  input wire logic ref_clk_i,
  // storage port
  bdm_ram_if.mem ram
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } bdm_ram_state_t;

  bdm_ram_state_t q;
  bdm_ram_state_t next_q;

  always_comb begin
    next_q = q;
    if (ram.we && ram.addr < DEPTH) begin
      next_q.mem[ram.addr] = ram.wdata;
    end
  end

  // no reset on purpose: contents survive every reset source
  always_ff @(posedge ref_clk_i) begin
    q <= next_q;
  end

  assign ram.rdata = (ram.addr < DEPTH) ? q.mem[ram.addr] : 8'h00;

endmodule

`default_nettype wire

// ---- verilog/bdm_ram_if.sv ----
/*
  Port between the address/control logic and the storage array.
  Assumes one clock; the storage answers reads combinationally.
*/
`timescale 1ns/1ns
`default_nettype none

interface bdm_ram_if;
  logic [11:0] addr;
  logic we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface

`default_nettype wire
